/* rtl/ahcs_pkg.sv */
// package: register map, field layout and encodings of the axis home sequencer
package ahcs_pkg;
	// register byte offsets
	localparam logic [7:0] AHCS_CTRL_OFS = 8'h00;
	localparam logic [7:0] AHCS_STAT_OFS = 8'h04;
	localparam logic [7:0] AHCS_SVEL_OFS = 8'h08;
	localparam logic [7:0] AHCS_FVEL_OFS = 8'h0c;
	localparam logic [7:0] AHCS_JVEL_OFS = 8'h10;
	localparam logic [7:0] AHCS_HOFS_OFS = 8'h14;
	localparam logic [7:0] AHCS_HPOS_OFS = 8'h18;
	localparam logic [7:0] AHCS_CPOS_OFS = 8'h1c;
	localparam logic [7:0] AHCS_APOS_OFS = 8'h20;
	localparam logic [7:0] AHCS_REQ_OFS = 8'h24;
	localparam logic [7:0] AHCS_REF_OFS = 8'h28;
	// ctrl field positions
	localparam int AHCS_C_HOME = 0;
	localparam int AHCS_C_EN = 1;
	localparam int AHCS_C_ABORT = 2;
	localparam int AHCS_C_JOGP = 3;
	localparam int AHCS_C_JOGM = 4;
	// status field positions
	localparam int AHCS_S_VALID = 0;
	localparam int AHCS_S_BUSY = 1;
	localparam int AHCS_S_CONFL = 2;
	localparam int AHCS_S_REFUSED = 3;
	localparam int AHCS_S_ABORTED = 4;
	localparam int AHCS_S_STEP = 8;
	localparam int AHCS_S_DIR = 12;
	localparam int AHCS_S_MOVING = 13;
	// motion request codes written to the request register
	localparam logic [3:0] AHCS_RQ_PROG = 4'h1;
	localparam logic [3:0] AHCS_RQ_VEL = 4'h2;
	localparam logic [3:0] AHCS_RQ_MOVE = 4'h3;
	localparam logic [3:0] AHCS_RQ_FORCE = 4'h4;
	localparam logic [3:0] AHCS_RQ_INCR = 4'h5;
	// reset values
	localparam logic [31:0] AHCS_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] AHCS_VEL_RST = 32'h0000_0000;
	// velocity source select
	typedef enum logic [1:0] {
		AHCS_V_NONE = 2'b00,
		AHCS_V_SEARCH = 2'b01,
		AHCS_V_FINAL = 2'b10,
		AHCS_V_JOG = 2'b11
	} ahcs_vsel_t;
	// home sequence steps
	typedef enum logic [3:0] {
		AHCS_IDLE = 4'b0000,
		AHCS_NEG_SRCH = 4'b0001,
		AHCS_STOP1 = 4'b0010,
		AHCS_POS_SRCH = 4'b0011,
		AHCS_STOP2 = 4'b0100,
		AHCS_NEG_FINAL = 4'b0101,
		AHCS_MARK_WAIT = 4'b0110,
		AHCS_STOP3 = 4'b0111,
		AHCS_OFS_MOVE = 4'b1000,
		AHCS_STOP4 = 4'b1001,
		AHCS_DONE = 4'b1010,
		AHCS_HALT = 4'b1011
	} ahcs_state_t;
	// motion command to the profile generator
	typedef struct packed {
		logic run;
		logic neg;
		logic jog_accel;
		ahcs_vsel_t vsel;
	} ahcs_motion_t;
	// inputs from the machine
	typedef struct packed {
		logic home_sw;
		logic marker;
		logic stopped;
		logic at_target;
	} ahcs_mach_t;
endpackage

/* rtl/ahcs_top.sv */
// axis home cycle sequencer with motion interlocks and apb registers
//
// Operation
// - a home cycle starts on a rising edge of the find-home bit
// - find-home clears position-valid at once, until the cycle completes
// - abort halts the home cycle; position-valid stays cleared
// - motion programs are refused while position-valid is clear
// - open home switch means positive side, closed means negative side
// - switch 0 starts at step one; switch 1 starts at positive search
// - move negative at search speed until switch closes, then stop
// - move positive at search speed until switch opens, then stop
// - move negative at final speed past closing until marker latches
// - after the marker, decelerate to stop beyond the marker
// - move at jog speed by home offset from the reference, stop
// - at completion load both positions with home position, set valid
// - homing ramps use jog acceleration and jog acceleration mode
// - during active motion any other motion request flags an error
// - position increment is accepted any time without conflict error
// - stops and non-programmed moves use jog accel; feed hold programmed (here feed_hold_prog_accel_q stays low except one cycle after reset)
// - directional marker modes take the first marker in direction
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ahcs_top
	import ahcs_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// machine pins and profile generator feedback
	input wire logic home_sw_in,
	input wire logic marker_in,
	input wire logic stopped_in,
	input wire logic at_target_in,
	// command to the profile generator
	output ahcs_motion_t motion_q,
	output logic [31:0] target_q,
	output logic feed_hold_prog_accel_q
);

	// --------------------------------------------------------------
	// input synchronisers
	// --------------------------------------------------------------
	ahcs_mach_t meta_q, mach_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			mach_q <= '0;
		end else begin
			meta_q <= {home_sw_in, marker_in, stopped_in, at_target_in};
			mach_q <= meta_q;
		end
	end
	logic marker_d1_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			marker_d1_q <= 1'b0;
		else
			marker_d1_q <= mach_q.marker;
	end
	logic marker_rise;
	assign marker_rise = mach_q.marker & ~marker_d1_q;

	// --------------------------------------------------------------
	// apb decode
	// --------------------------------------------------------------
	logic acc, wr;
	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;
	logic [31:0] ctrl_q, svel_q, fvel_q, jvel_q, hofs_q, hpos_q;
	logic [31:0] cpos_q, apos_q, ref_q;
	logic valid_q, confl_q, refused_q, aborted_q;
	ahcs_state_t st_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= AHCS_CTRL_RST;
			svel_q <= AHCS_VEL_RST;
			fvel_q <= AHCS_VEL_RST;
			jvel_q <= AHCS_VEL_RST;
			hofs_q <= AHCS_VEL_RST;
			hpos_q <= AHCS_VEL_RST;
		end else if (wr) begin
			case (paddr)
			AHCS_CTRL_OFS: ctrl_q <= pwdata;
			AHCS_SVEL_OFS: svel_q <= pwdata;
			AHCS_FVEL_OFS: fvel_q <= pwdata;
			AHCS_JVEL_OFS: jvel_q <= pwdata;
			AHCS_HOFS_OFS: hofs_q <= pwdata;
			AHCS_HPOS_OFS: hpos_q <= pwdata;
			default: ;
			endcase
		end
	end

	logic mapped;
	always_comb begin
		case (paddr)
		AHCS_CTRL_OFS, AHCS_STAT_OFS, AHCS_SVEL_OFS, AHCS_FVEL_OFS,
		AHCS_JVEL_OFS, AHCS_HOFS_OFS, AHCS_HPOS_OFS, AHCS_CPOS_OFS,
		AHCS_APOS_OFS, AHCS_REQ_OFS, AHCS_REF_OFS: mapped = 1'b1;
		default: mapped = 1'b0;
		endcase
	end

	logic [31:0] stat;
	always_comb begin
		stat = '0;
		stat[AHCS_S_VALID] = valid_q;
		stat[AHCS_S_BUSY] = (st_q != AHCS_IDLE);
		stat[AHCS_S_CONFL] = confl_q;
		stat[AHCS_S_REFUSED] = refused_q;
		stat[AHCS_S_ABORTED] = aborted_q;
		stat[AHCS_S_STEP +: 4] = st_q;
		stat[AHCS_S_DIR] = motion_q.neg;
		stat[AHCS_S_MOVING] = motion_q.run;
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel & penable & ~pready & ~pwrite) begin
				case (paddr)
				AHCS_CTRL_OFS: prdata <= ctrl_q;
				AHCS_STAT_OFS: prdata <= stat;
				AHCS_SVEL_OFS: prdata <= svel_q;
				AHCS_FVEL_OFS: prdata <= fvel_q;
				AHCS_JVEL_OFS: prdata <= jvel_q;
				AHCS_HOFS_OFS: prdata <= hofs_q;
				AHCS_HPOS_OFS: prdata <= hpos_q;
				AHCS_CPOS_OFS: prdata <= cpos_q;
				AHCS_APOS_OFS: prdata <= apos_q;
				AHCS_REF_OFS: prdata <= ref_q;
				default: prdata <= '0;
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// command bits
	// --------------------------------------------------------------
	logic home_bit, en_bit, abort_bit, jog_bit, home_prev_q, home_rise;
	assign home_bit = ctrl_q[AHCS_C_HOME];
	assign en_bit = ctrl_q[AHCS_C_EN];
	assign abort_bit = ctrl_q[AHCS_C_ABORT];
	assign jog_bit = ctrl_q[AHCS_C_JOGP] ^ ctrl_q[AHCS_C_JOGM];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			home_prev_q <= 1'b0;
		else
			home_prev_q <= home_bit;
	end
	assign home_rise = home_bit & ~home_prev_q;

	// --------------------------------------------------------------
	// home sequence
	// --------------------------------------------------------------
	logic start_home, kill;
	assign kill = abort_bit | ~en_bit;
	assign start_home = home_rise & (st_q == AHCS_IDLE) & en_bit & ~abort_bit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= AHCS_IDLE;
		end else if (st_q != AHCS_IDLE && st_q != AHCS_HALT && kill) begin
			st_q <= AHCS_HALT;
		end else begin
			case (st_q)
			AHCS_IDLE:
				if (start_home)
					st_q <= mach_q.home_sw ? AHCS_POS_SRCH
						: AHCS_NEG_SRCH;
			AHCS_NEG_SRCH:
				if (mach_q.home_sw)
					st_q <= AHCS_STOP1;
			AHCS_STOP1:
				if (mach_q.stopped)
					st_q <= AHCS_POS_SRCH;
			AHCS_POS_SRCH:
				if (!mach_q.home_sw)
					st_q <= AHCS_STOP2;
			AHCS_STOP2:
				if (mach_q.stopped)
					st_q <= AHCS_NEG_FINAL;
			AHCS_NEG_FINAL:
				if (mach_q.home_sw)
					st_q <= AHCS_MARK_WAIT;
			AHCS_MARK_WAIT:
				if (marker_rise)
					st_q <= AHCS_STOP3;
			AHCS_STOP3:
				if (mach_q.stopped)
					st_q <= AHCS_OFS_MOVE;
			AHCS_OFS_MOVE:
				if (mach_q.at_target)
					st_q <= AHCS_STOP4;
			AHCS_STOP4:
				if (mach_q.stopped)
					st_q <= AHCS_DONE;
			AHCS_DONE:
				st_q <= AHCS_IDLE;
			AHCS_HALT:
				if (mach_q.stopped)
					st_q <= AHCS_IDLE;
			default:
				st_q <= AHCS_IDLE;
			endcase
		end
	end

	// reference latch and status positions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ref_q <= '0;
		else if (st_q == AHCS_MARK_WAIT && marker_rise)
			ref_q <= apos_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpos_q <= '0;
			apos_q <= '0;
		end else if (st_q == AHCS_DONE && !kill) begin
			cpos_q <= hpos_q;
			apos_q <= hpos_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			valid_q <= 1'b0;
		else if (home_rise || st_q == AHCS_HALT)
			valid_q <= 1'b0;
		else if (st_q == AHCS_DONE && !kill)
			valid_q <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			aborted_q <= 1'b0;
		else if (st_q != AHCS_IDLE && st_q != AHCS_HALT && kill)
			aborted_q <= 1'b1;
		else if (start_home)
			aborted_q <= 1'b0;
	end

	// --------------------------------------------------------------
	// motion command
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motion_q <= '0;
			target_q <= '0;
		end else begin
			motion_q.jog_accel <= 1'b1;
			motion_q.run <= 1'b0;
			motion_q.neg <= 1'b0;
			motion_q.vsel <= AHCS_V_NONE;
			target_q <= '0;
			case (st_q)
			AHCS_NEG_SRCH: begin
				motion_q.run <= 1'b1;
				motion_q.neg <= 1'b1;
				motion_q.vsel <= AHCS_V_SEARCH;
			end
			AHCS_POS_SRCH: begin
				motion_q.run <= 1'b1;
				motion_q.vsel <= AHCS_V_SEARCH;
			end
			AHCS_NEG_FINAL, AHCS_MARK_WAIT: begin
				motion_q.run <= 1'b1;
				motion_q.neg <= 1'b1;
				motion_q.vsel <= AHCS_V_FINAL;
			end
			AHCS_OFS_MOVE: begin
				motion_q.run <= 1'b1;
				motion_q.vsel <= AHCS_V_JOG;
				target_q <= ref_q + hofs_q;
			end
			default: ;
			endcase
		end
	end

	// feed hold flag is the registered inverse of jog_accel, so it is high for one cycle after reset, then stays low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			feed_hold_prog_accel_q <= 1'b0;
		else
			feed_hold_prog_accel_q <= ~motion_q.jog_accel;
	end

	// --------------------------------------------------------------
	// motion request interlocks
	// --------------------------------------------------------------
	logic req_wr, active;
	logic [3:0] req_code;
	assign req_wr = wr && paddr == AHCS_REQ_OFS;
	assign req_code = pwdata[3:0];
	assign active = (st_q != AHCS_IDLE) | jog_bit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			confl_q <= 1'b0;
		else if (req_wr && active && req_code != AHCS_RQ_INCR)
			confl_q <= 1'b1;
		else if (wr && paddr == AHCS_STAT_OFS && pwdata[AHCS_S_CONFL])
			confl_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			refused_q <= 1'b0;
		else if (req_wr && req_code == AHCS_RQ_PROG && !valid_q)
			refused_q <= 1'b1;
		else if (wr && paddr == AHCS_STAT_OFS && pwdata[AHCS_S_REFUSED])
			refused_q <= 1'b0;
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	valid_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		home_rise |=> !valid_q) else $error("valid not cleared");
	valid_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q != AHCS_IDLE |-> !valid_q) else $error("valid while busy");
	start_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
		start_home |=> st_q == ($past(mach_q.home_sw) ? AHCS_POS_SRCH
		: AHCS_NEG_SRCH)) else $error("wrong start step");
	abort_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q != AHCS_IDLE && st_q != AHCS_HALT && abort_bit) |=> st_q == AHCS_HALT)
		else $error("abort ignored");
	done_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == AHCS_DONE && !kill) |=> valid_q == !$past(home_rise)
		&& cpos_q == $past(hpos_q) && apos_q == $past(hpos_q))
		else $error("completion load wrong");
	prog_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
		(req_wr && req_code == AHCS_RQ_PROG && !valid_q) |=> refused_q)
		else $error("program not refused");
	incr_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
		(req_wr && req_code == AHCS_RQ_INCR && !confl_q) |=> !confl_q)
		else $error("increment flagged");
endmodule
`default_nettype wire

/* sim/ahcs_axis_model.sv */
// axis model: position, home switch, marker and profile feedback
`timescale 1ns/1ps
`default_nettype none
module ahcs_axis_model
	import ahcs_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// command from the sequencer
	input wire ahcs_motion_t motion,
	// machine side
	output logic home_sw,
	output logic marker,
	output logic stopped,
	output logic at_target
);
	// ---------------------------------------------------------------
	// one count per cycle of travel
	// ---------------------------------------------------------------
	int pos = 30;
	int jog_n = 0;
	always @(posedge pclk) begin
		if (motion.run) begin
			pos <= motion.neg ? pos - 1 : pos + 1;
		end
		jog_n <= (presetn && motion.run && motion.vsel == AHCS_V_JOG) ?
			jog_n + 1 : 0;
		stopped <= !motion.run;
	end
	// closed below zero, the negative side of the switch
	assign home_sw = (pos < 0);
	// one marker pulse every eight counts
	assign marker = (pos[2:0] == 3'h0);
	assign at_target = (jog_n >= 4);
endmodule
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the axis home cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module tb
	import ahcs_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn;
	logic psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr;
	logic home_sw, marker, stopped, at_target, fh_accel;
	ahcs_motion_t motion;
	logic [31:0] target, rdat, hp, ho, tgt;
	logic rerr;
	logic [2:0] seq[$];
	logic [2:0] prev = 3'h0;
	logic prev_run = 1'b0;
	int mismatches = 0;
	int checks_done = 0;

	always #10 pclk = ~pclk;

	ahcs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.home_sw_in(home_sw), .marker_in(marker), .stopped_in(stopped),
		.at_target_in(at_target), .motion_q(motion), .target_q(target),
		.feed_hold_prog_accel_q(fh_accel));
	ahcs_axis_model axis_u (.pclk(pclk), .presetn(presetn),
		.motion(motion), .home_sw(home_sw), .marker(marker),
		.stopped(stopped), .at_target(at_target));

	// ---------------------------------------------------------------
	// motion step recorder
	// ---------------------------------------------------------------
	always @(posedge pclk) begin
		prev_run <= motion.run;
		prev <= {motion.neg, motion.vsel};
		if (motion.run && (!prev_run || {motion.neg, motion.vsel} != prev)) begin
			seq.push_back({motion.neg, motion.vsel});
		end
		if (motion.run && motion.vsel == AHCS_V_JOG) begin
			tgt <= target;
		end
	end

	// ---------------------------------------------------------------
	// tasks and expectations
	// ---------------------------------------------------------------
	task automatic wrap_up;
		if (mismatches == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic home(input int start);
		axis_u.pos = start;
		seq.delete();
		wr(AHCS_CTRL_OFS, 32'h0000_0003);
		wr(AHCS_CTRL_OFS, 32'h0000_0002);
	endtask

	task automatic wait_idle;
		rd(AHCS_STAT_OFS);
		for (int i = 0; i < 300 && rdat[AHCS_S_BUSY] !== 1'b0; i++) begin
			rd(AHCS_STAT_OFS);
		end
		chk("busy", 32'h0, {31'h0, rdat[AHCS_S_BUSY]});
	endtask

	function automatic logic [2:0] exp_step(input int k);
		case (k)
			0: return {1'b1, AHCS_V_SEARCH};
			1: return {1'b0, AHCS_V_SEARCH};
			2: return {1'b1, AHCS_V_FINAL};
			default: return {1'b0, AHCS_V_JOG};
		endcase
	endfunction

	task automatic chk_seq(input int first);
		logic [2:0] e;
		chk("steps", 32'(4 - first), 32'(seq.size()));
		for (int i = 0; i < 4 - first; i++) begin
			e = exp_step(i + first);
			if (i + first == 3) begin
				chk("jog", {30'h0, e[1:0]}, {30'h0, seq[i][1:0]});
			end else begin
				chk("step", {29'h0, e}, {29'h0, seq[i]});
			end
		end
	endtask

	task automatic stat_is(input logic [31:0] mask, input logic [31:0] e);
		rd(AHCS_STAT_OFS);
		chk("stat", e, rdat & mask);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		presetn = 1'b0;
		void'($urandom(27));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(AHCS_CTRL_OFS);
		chk("ctrl", AHCS_CTRL_RST, rdat);
		rd(AHCS_SVEL_OFS);
		chk("svel", AHCS_VEL_RST, rdat);
		rd(8'h3c);
		chk("slverr", 32'h1, {31'h0, rerr});
		chk("bad_rd", 32'h0, rdat);
		wr(AHCS_REQ_OFS, {28'h0, AHCS_RQ_PROG});
		stat_is(32'h9, 32'h8);
		hp = $urandom;
		wr(AHCS_HPOS_OFS, hp);
		wr(AHCS_SVEL_OFS, $urandom);
		wr(AHCS_FVEL_OFS, $urandom);
		wr(AHCS_JVEL_OFS, $urandom);
		ho = 32'(1 + $urandom_range(99));
		wr(AHCS_HOFS_OFS, ho);
		// open switch start, with requests during the cycle
		home(70 + $urandom_range(20));
		wr(AHCS_REQ_OFS, {28'h0, AHCS_RQ_INCR});
		stat_is(32'h4, 32'h0);
		for (int c = 1; c < 5; c++) begin
			wr(AHCS_STAT_OFS, 32'h0000_000c);
			wr(AHCS_REQ_OFS, 32'(c));
			stat_is(32'h4, 32'h4);
		end
		wait_idle();
		chk_seq(0);
		chk("jog_accel", 32'h1, {31'h0, motion.jog_accel});
		chk("fh_accel", 32'h0, {31'h0, fh_accel});
		rd(AHCS_CPOS_OFS);
		chk("cpos", hp, rdat);
		rd(AHCS_APOS_OFS);
		chk("apos", hp, rdat);
		chk("target", ho, tgt);
		rd(AHCS_REF_OFS);
		chk("ref", 32'h0, rdat);
		wr(AHCS_STAT_OFS, 32'h0000_001c);
		wr(AHCS_REQ_OFS, {28'h0, AHCS_RQ_PROG});
		stat_is(32'h9, 32'h1);
		// a single jog bit counts as active motion, both bits do not
		wr(AHCS_CTRL_OFS, 32'h0000_000a);
		wr(AHCS_REQ_OFS, {28'h0, AHCS_RQ_VEL});
		stat_is(32'h4, 32'h4);
		wr(AHCS_STAT_OFS, 32'h0000_0004);
		wr(AHCS_CTRL_OFS, 32'h0000_001a);
		wr(AHCS_REQ_OFS, {28'h0, AHCS_RQ_MOVE});
		stat_is(32'h4, 32'h0);
		// closed switch start
		home(-5);
		stat_is(32'h1, 32'h0);
		wait_idle();
		chk_seq(1);
		stat_is(32'h1, 32'h1);
		chk("target", hp + ho, tgt);
		// abort, then drive enable loss
		home(70);
		wr(AHCS_CTRL_OFS, 32'h0000_0006);
		wait_idle();
		stat_is(32'h13, 32'h10);
		wr(AHCS_STAT_OFS, 32'h0000_001c);
		home(70);
		wr(AHCS_CTRL_OFS, 32'h0000_0000);
		wait_idle();
		stat_is(32'h13, 32'h10);
		wrap_up();
	end

	initial begin
		#1_000_000;
		mismatches++;
		wrap_up();
	end
endmodule
`default_nettype wire
